/* File: dv/ldl_display_ram_loader_bench.sv */
// Self-checking bench for the display RAM loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin nErrors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ldl_display_ram_loader_bench;
   logic clk, rstn, inValid, inReady, inBit, dataAbort, ptrOverflow, alt;
   logic loadPtrValid, devSelValid, modeValid, bankValid, bankAltValue;
   logic [4:0] loadPtrValue, dataPtr, expPtr;
   logic [2:0] devSelValue, subCount, pins, expSub;
   logic [1:0] modeValue, activeRow, mode;
   logic [31:0] segRow;
   logic [3:0] expRam [32];
   int nErrors = 0;
   int comparisons = 0;
   ldl_display_ram_loader DUT (.clk(clk), .rstn(rstn), .inValid(inValid), .inReady(inReady),
      .inBit(inBit), .dataAbort(dataAbort), .loadPtrValid(loadPtrValid),
      .loadPtrValue(loadPtrValue), .devSelValid(devSelValid), .devSelValue(devSelValue),
      .modeValid(modeValid), .modeValue(modeValue), .bankValid(bankValid),
      .bankAltValue(bankAltValue), .hw_subaddr_pin_0(pins[0]), .hw_subaddr_pin_1(pins[1]),
      .hw_subaddr_pin_2(pins[2]), .activeRow(activeRow), .segRow(segRow),
      .dataPtr(dataPtr), .subCount(subCount), .ptrOverflow(ptrOverflow));
   ldl_master_model mst (.clk(clk), .inReady(inReady), .inValid(inValid), .inBit(inBit));
   // ****************************************
   // Helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : cyc
   // One command pulse: 0 pointer, 1 device select, 2 mode, 3 bank
   task cmd(input int k, input logic [4:0] v);
      case (k)
         0: begin loadPtrValid = 1'b1; loadPtrValue = v; expPtr = v; end
         1: begin devSelValid = 1'b1; devSelValue = v[2:0]; expSub = v[2:0]; end
         2: begin modeValid = 1'b1; modeValue = v[1:0]; mode = v[1:0]; end
         default: begin bankValid = 1'b1; bankAltValue = v[0]; alt = v[0]; end
      endcase
      cyc(1);
      {loadPtrValid, devSelValid, modeValid, bankValid} = 4'h0;
   endtask : cmd
   task chk_ram;
      logic [31:0] v;
      for (int r = 0; r < 4; r++) begin
         activeRow = 2'(r);
         cyc(2);
         for (int w = 0; w < 32; w++) v[w] = expRam[w][r];
         `CHK(segRow, v)
      end
   endtask : chk_ram
   // Places a byte in the model RAM, sends it, checks pointer side effects
   task send_byte(input logic [7:0] b, input int gap);
      int n;
      logic wr, ovf, saw;
      n = int'(mode) + 1;
      wr = (expSub == pins);
      saw = 1'b0;
      for (int j = 0; j < 8; j++)
         if (wr) expRam[5'(expPtr + j / n)][j % n + ((alt && mode < 2) ? 2 : 0)] = b[7 - j];
      ovf = (int'(expPtr) + (7 + n) / n) > 31;
      expPtr = 5'(int'(expPtr) + (7 + n) / n);
      if (ovf) expSub = expSub + 3'h1;
      mst.send(b, 8, gap);
      for (int i = 0; i < 30; i++) begin
         saw |= (ptrOverflow === 1'b1);
         if (dataPtr === expPtr) break;
         cyc(1);
      end
      `CHK(dataPtr, expPtr)
      `CHK(saw, ovf)
      `CHK(subCount, expSub)
   endtask : send_byte
   task final_report;
      if (nErrors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   // ****************************************
   // Scenarios
   // ****************************************
   task t_modes;
      for (int m = 0; m < 4; m++) begin
         cmd(2, 5'(m));
         cmd(0, 5'(m * 7 + 3));
         send_byte(8'hc5 ^ 8'(m * 16), 0);
         send_byte(8'h3a + 8'(m), 2);
         chk_ram;
      end
   endtask : t_modes
   task t_bank;
      cmd(3, 5'h01);
      for (int m = 0; m < 2; m++) begin
         cmd(2, 5'(m));
         cmd(0, 5'h10);
         send_byte(8'h96, 0);
      end
      chk_ram;
      cmd(3, 5'h00);
   endtask : t_bank
   task t_sub;
      cmd(1, 5'h05);
      send_byte(8'hff, 0);
      chk_ram;
      cmd(1, 5'h00);
   endtask : t_sub
   task t_ovf;
      cmd(2, 5'h03);
      cmd(0, 5'h1f);
      send_byte(8'h5a, 0);
      send_byte(8'ha5, 0);
      pins = 3'h1; // Pins move only between accesses
      cyc(3);
      send_byte(8'h81, 1);
      chk_ram;
      pins = 3'h0;
      cmd(1, 5'h00);
      cyc(3);
   endtask : t_ovf
   task t_abort;
      cmd(2, 5'h01);
      cmd(0, 5'h08);
      mst.send(8'hf0, 3, 0);
      dataAbort = 1'b1;
      #1;
      `CHK(inReady, 1'b0)
      cyc(1);
      dataAbort = 1'b0;
      cmd(0, 5'h08); // Reload after the cut transfer
      send_byte(8'h3c, 0);
      chk_ram;
   endtask : t_abort
   // Commands stall draining; the buffer must refuse, then lose nothing
   task t_stall;
      cmd(2, 5'h03);
      cmd(0, 5'h14);
      fork
         begin
            devSelValid = 1'b1;
            devSelValue = expSub;
            cyc(4);
            `CHK(inReady, 1'b0)
            devSelValid = 1'b0;
         end
         send_byte(8'hd2, 0);
      join
      chk_ram;
   endtask : t_stall
   initial begin
      {rstn, dataAbort, loadPtrValid, devSelValid, modeValid, bankValid, bankAltValue} = 7'h0;
      {loadPtrValue, devSelValue, modeValue, pins, activeRow} = 15'h0;
      {expPtr, expSub, mode, alt} = 11'h0;
      repeat (6) @(posedge clk);
      #1;
      rstn = 1'b1;
      cyc(1);
      `CHK(dataPtr, 5'h00)
      `CHK(subCount, 3'h0)
      cyc(2);
      t_modes;
      t_bank;
      t_sub;
      t_ovf;
      t_abort;
      t_stall;
      final_report;
   end
   // Whole run needs a few hundred cycles
   initial begin
      #(50 * 20000);
      nErrors++;
      final_report;
   end
endmodule : ldl_display_ram_loader_bench
`default_nettype wire

/* File: dv/ldl_display_ram_loader_props.sv */
// Concurrent checks on the display RAM loader ports
`timescale 1ns/1ps
`default_nettype none
module ldl_loader_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic loadPtrValid,
   input wire logic [4:0] loadPtrValue,
   input wire logic devSelValid,
   input wire logic [2:0] devSelValue,
   input wire logic [4:0] dataPtr,
   input wire logic [2:0] subCount,
   input wire logic ptrOverflow
);
   // ****************************************
   // Pointer and subaddress properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Wrap not overridden by a device-select
   sequence sWrap;
      ptrOverflow && !$past(devSelValid);
   endsequence
   sequence sFreeMove;
      $past(rstn) && !$past(loadPtrValid) && dataPtr != $past(dataPtr);
   endsequence
   a_reset_clear: assert property ($rose(rstn) |-> dataPtr == 5'h00 && subCount == 3'h0)
      else $error("pointer or subaddress not cleared");
   a_ptr_load: assert property (loadPtrValid |=> dataPtr == $past(loadPtrValue))
      else $error("pointer load ignored");
   a_sub_load: assert property (devSelValid |=> subCount == $past(devSelValue))
      else $error("subaddress load ignored");
   a_sub_inc: assert property (sWrap |-> subCount == $past(subCount) + 3'h1)
      else $error("subaddress not bumped on wrap");
   a_ovf_pulse: assert property (ptrOverflow |=> !ptrOverflow)
      else $error("overflow longer than a cycle");
   a_ovf_wrap: assert property (ptrOverflow && !$past(loadPtrValid) |-> dataPtr < $past(dataPtr))
      else $error("overflow without wrap");
   a_ptr_step: assert property (sFreeMove |-> 5'(dataPtr - $past(dataPtr)) inside {8, 4, 3, 2})
      else $error("pointer step wrong");
   a_sub_hold: assert property ($past(rstn) && subCount != $past(subCount)
      |-> $past(devSelValid) || ptrOverflow)
      else $error("subaddress moved alone");
endmodule : ldl_loader_props
bind ldl_display_ram_loader ldl_loader_props u_props (.clk(clk), .rstn(rstn),
   .loadPtrValid(loadPtrValid), .loadPtrValue(loadPtrValue), .devSelValid(devSelValid),
   .devSelValue(devSelValue), .dataPtr(dataPtr), .subCount(subCount),
   .ptrOverflow(ptrOverflow));
`default_nettype wire

/* File: dv/ldl_master_model.sv */
// Bus master model that feeds display bits to the loader
`timescale 1ns/1ps
`default_nettype none
module ldl_master_model (
   input wire logic clk,
   input wire logic inReady,
   output logic inValid,
   output logic inBit
);
   initial begin
      inValid = 1'b0;
      inBit = 1'b0;
   end
   // Sends top n bits MSB first, gap idle cycles after each bit
   task automatic send(input logic [7:0] b, input int n, input int gap);
      logic rdy;
      for (int j = 0; j < n; j++) begin
         inValid = 1'b1;
         inBit = b[7 - j];
         // Hold until the block accepts; a stall may last any time
         do begin
            rdy = inReady;
            @(posedge clk);
            #1;
         end while (!rdy);
         if (gap > 0 || j == n - 1) begin
            inValid = 1'b0;
            inBit = ~inBit; // Released line shows no stale data
         end
         repeat (gap) begin
            @(posedge clk);
            #1;
         end
      end
   endtask : send
endmodule : ldl_master_model
`default_nettype wire

/* File: hw/ldl_display_ram_loader.sv */
// Display RAM write path: bit placement, data pointer, subaddress gating
`timescale 1ns/1ps
`default_nettype none
`include "ldl_params.svh"

// Operation
// - Display memory is 32 words of 4 bits; 1 means element on.
// - Word address selects segment output, bit position selects backplane row.
// - During backplane slot k, segments show memory row k.
// - Display bits are written as each arrives, not after acknowledge.
// - Static mode: one bit per word, row 0, eight words.
// - 1:2 mode: bit pairs into rows 0 and 1 of four words.
// - 1:3 mode: triples into rows 0-2; last word row 3 untouched.
// - 1:4 mode: four bits per word filling rows 0-3, two words.
// - Load-pointer command sets address where next byte starts.
// - Pointer advances 8, 4, 3 or 2 after each byte by mode.
// - Data stored only while subaddress counter equals subaddress pins.
// - Device-select command loads the subaddress counter.
// - On subaddress mismatch the write is dropped, pointer still advances.
// - Subaddress counter increments by one on each pointer overflow.
// - Reset clears pointer and subaddress counter to zero.
// - Alternate bank moves static data to row 2, 1:2 to rows 2-3.
module ldl_display_ram_loader (
   input wire logic clk,
   input wire logic rstn,
   // Serial display bits from the bus front end, first bit = MSB
   input wire logic inValid,
   output logic inReady,
   input wire logic inBit,
   input wire logic dataAbort,
   // Decoded commands, one-cycle pulses
   input wire logic loadPtrValid,
   input wire logic [4:0] loadPtrValue,
   input wire logic devSelValid,
   input wire logic [2:0] devSelValue,
   input wire logic modeValid,
   input wire logic [1:0] modeValue,
   input wire logic bankValid,
   input wire logic bankAltValue,
   // Hardware subaddress pins, asynchronous
   input wire logic hw_subaddr_pin_0,
   input wire logic hw_subaddr_pin_1,
   input wire logic hw_subaddr_pin_2,
   // Multiplex slot from the output side
   input wire logic [1:0] activeRow,
   output logic [31:0] segRow,
   output logic [4:0] dataPtr,
   output logic [2:0] subCount,
   output logic ptrOverflow
);

   // ****************************************
   // Placement helpers
   // ****************************************

   // Word offset of bit j inside the current byte
   function automatic logic [4:0] wordOffset(input ldl_pkg::ldl_mode_e m, input logic [2:0] j);
      logic [4:0] r;
      r = 5'h00;
      case (m)
         ldl_pkg::LDL_STATIC: r = {2'h0, j};
         ldl_pkg::LDL_MUX2: r = {3'h0, j[2:1]};
         ldl_pkg::LDL_MUX3: begin
            if (j >= 3'h6) begin
               r = 5'h02;
            end else if (j >= 3'h3) begin
               r = 5'h01;
            end else begin
               r = 5'h00;
            end
         end
         default: r = {4'h0, j[2]};
      endcase
      return r;
   endfunction : wordOffset

   // Row of bit j; alternate bank only matters in static and 1:2
   function automatic logic [1:0] rowOf(input ldl_pkg::ldl_mode_e m, input logic [2:0] j,
                                        input logic alt);
      logic [1:0] base;
      logic [1:0] r;
      base = alt ? `LDL_ALT_ROW_BASE : 2'h0;
      r = 2'h0;
      case (m)
         ldl_pkg::LDL_STATIC: r = base;
         ldl_pkg::LDL_MUX2: r = base | {1'b0, j[0]};
         ldl_pkg::LDL_MUX3: begin
            // Rows 0..2 only, so row 3 of the third word is never hit
            if (j == 3'h0 || j == 3'h3 || j == 3'h6) begin
               r = 2'h0;
            end else if (j == 3'h1 || j == 3'h4 || j == 3'h7) begin
               r = 2'h1;
            end else begin
               r = 2'h2;
            end
         end
         default: r = j[1:0];
      endcase
      return r;
   endfunction : rowOf

   // Pointer step per byte
   function automatic logic [5:0] stepOf(input ldl_pkg::ldl_mode_e m);
      logic [5:0] s;
      s = `LDL_STEP_MUX4;
      case (m)
         ldl_pkg::LDL_STATIC: s = `LDL_STEP_STATIC;
         ldl_pkg::LDL_MUX2: s = `LDL_STEP_MUX2;
         ldl_pkg::LDL_MUX3: s = `LDL_STEP_MUX3;
         default: s = `LDL_STEP_MUX4;
      endcase
      return s;
   endfunction : stepOf

   // ****************************************
   // State
   // ****************************************
   ldl_pkg::ldl_state_s st_r;
   ldl_pkg::ldl_state_s st_nxt;

   logic cmdBusy;
   logic push;
   logic pop;
   logic headBit;
   logic subMatch;
   logic [4:0] wrWord;
   logic [1:0] wrRow;
   logic [5:0] ptrSum;

   // Commands own the cycle, so the drain stalls and the buffer fills
   assign cmdBusy = loadPtrValid | devSelValid | modeValid | bankValid;
   assign inReady = (st_r.fifoCnt != `LDL_FIFO_DEPTH) && !dataAbort;
   assign push = inValid & inReady;
   assign pop = (st_r.fifoCnt != 2'h0) && !cmdBusy && !dataAbort;
   assign headBit = st_r.fifoBits[0];
   assign subMatch = (st_r.sub == st_r.pinSync);

   // Placement of the bit at the buffer head
   assign wrWord = st_r.ptr + wordOffset(st_r.mode, st_r.bitCnt);
   assign wrRow = rowOf(st_r.mode, st_r.bitCnt, st_r.bankAlt);
   assign ptrSum = {1'b0, st_r.ptr} + stepOf(st_r.mode);

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.ovf = 1'b0;

      // Pin synchroniser; pins are assumed steady during access
      st_nxt.pinMeta = {hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0};
      st_nxt.pinSync = st_r.pinMeta;

      // Segment view of the row for the current slot
      for (int w = 0; w < `LDL_WORDS; w++) begin
         st_nxt.segRow[w] = st_r.ram[w][activeRow];
      end

      // Two-entry bit buffer
      case ({push, pop})
         2'b10: begin
            st_nxt.fifoBits[st_r.fifoCnt[0]] = inBit;
            st_nxt.fifoCnt = st_r.fifoCnt + 2'h1;
         end
         2'b01: begin
            st_nxt.fifoBits[0] = st_r.fifoBits[1];
            st_nxt.fifoCnt = st_r.fifoCnt - 2'h1;
         end
         2'b11: begin
            if (st_r.fifoCnt == 2'h1) begin
               st_nxt.fifoBits[0] = inBit;
            end else begin
               st_nxt.fifoBits[0] = st_r.fifoBits[1];
               st_nxt.fifoBits[1] = inBit;
            end
         end
         default: begin
         end
      endcase

      // Each bit lands in memory as soon as it is drained, if the subaddress matches
      if (pop) begin
         if (subMatch) begin
            st_nxt.ram[wrWord][wrRow] = headBit;
         end
         if (st_r.bitCnt == `LDL_LAST_BIT) begin
            st_nxt.bitCnt = 3'h0;
            st_nxt.ptr = ptrSum[4:0];
            if (ptrSum[5]) begin
               st_nxt.ovf = 1'b1;
               st_nxt.sub = st_r.sub + 3'h1;
            end
         end else begin
            st_nxt.bitCnt = st_r.bitCnt + 3'h1;
         end
      end

      // Aborted transfer drops buffered bits and restarts the bit count; bits already drained and the pointer stay
      if (dataAbort) begin
         st_nxt.bitCnt = 3'h0;
         st_nxt.fifoCnt = 2'h0;
      end

      // Commands
      if (loadPtrValid) begin
         st_nxt.ptr = loadPtrValue;
         st_nxt.bitCnt = 3'h0;
      end
      if (devSelValid) begin
         st_nxt.sub = devSelValue;
      end
      if (modeValid) begin
         st_nxt.mode = ldl_pkg::ldl_mode_e'(modeValue);
         st_nxt.bitCnt = 3'h0;
      end
      if (bankValid) begin
         st_nxt.bankAlt = bankAltValue;
      end
   end

   // ****************************************
   // State register
   // ****************************************

   // Memory contents are not cleared; only control state resets
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r.ram <= st_nxt.ram;
         st_r.ptr <= `LDL_PTR_RST;
         st_r.sub <= `LDL_SUB_RST;
         st_r.mode <= ldl_pkg::LDL_STATIC;
         st_r.bankAlt <= 1'b0;
         st_r.bitCnt <= 3'h0;
         st_r.fifoBits <= 2'h0;
         st_r.fifoCnt <= 2'h0;
         st_r.pinMeta <= 3'h0;
         st_r.pinSync <= 3'h0;
         st_r.segRow <= 32'h0000_0000;
         st_r.ovf <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign segRow = st_r.segRow;
   assign dataPtr = st_r.ptr;
   assign subCount = st_r.sub;
   assign ptrOverflow = st_r.ovf;

endmodule : ldl_display_ram_loader
`default_nettype wire

/* File: hw/ldl_params.svh */
// Constants for the display RAM loader: sizes, codes, reset values
`ifndef LDL_PARAMS_SVH
`define LDL_PARAMS_SVH

// ****************************************
// Memory geometry
// ****************************************
`define LDL_WORDS 32
`define LDL_ROWS 4
`define LDL_PTR_W 5
`define LDL_SUB_W 3

// ****************************************
// Drive mode codes
// ****************************************
`define LDL_MODE_STATIC 2'h0
`define LDL_MODE_MUX2 2'h1
`define LDL_MODE_MUX3 2'h2
`define LDL_MODE_MUX4 2'h3

// ****************************************
// Pointer steps per byte
// ****************************************
`define LDL_STEP_STATIC 6'h08
`define LDL_STEP_MUX2 6'h04
`define LDL_STEP_MUX3 6'h03
`define LDL_STEP_MUX4 6'h02

// ****************************************
// Reset values and byte framing
// ****************************************
`define LDL_PTR_RST 5'h00
`define LDL_SUB_RST 3'h0
`define LDL_LAST_BIT 3'h7
`define LDL_ALT_ROW_BASE 2'h2
`define LDL_FIFO_DEPTH 2'h2

`endif

/* File: hw/ldl_pkg.sv */
// Types shared by the display RAM loader
package ldl_pkg;

   // ****************************************
   // Drive modes
   // ****************************************
   typedef enum logic [1:0] {
      LDL_STATIC = 2'h0,
      LDL_MUX2 = 2'h1,
      LDL_MUX3 = 2'h2,
      LDL_MUX4 = 2'h3
   } ldl_mode_e;

   // ****************************************
   // Whole state of the loader
   // ****************************************
   typedef struct packed {
      logic [31:0][3:0] ram;
      logic [4:0] ptr;
      logic [2:0] sub;
      ldl_mode_e mode;
      logic bankAlt;
      logic [2:0] bitCnt;
      logic [1:0] fifoBits;
      logic [1:0] fifoCnt;
      logic [2:0] pinMeta;
      logic [2:0] pinSync;
      logic [31:0] segRow;
      logic ovf;
   } ldl_state_s;

endpackage : ldl_pkg
